// ---- dv/mtp_mem_model.sv ----
/*
 * Memory controller user port model: stores writes, returns each read one cycle later, in order.
 * Assumes the decoder's clock; slow halves cmd_ready, flip corrupts bit 0 of returned words.
 */
`default_nettype none

module mtp_mem_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic        flip,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [15:0] cmd_addr,
	input  wire logic [15:0] cmd_wdata,
	output logic             cmd_ready,
	output logic             rd_valid,
	output logic [15:0]      rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:255];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ready <= 1'b0;
			rd_valid  <= 1'b0;
			rd_data   <= 16'h5a5a;
		end else begin
			cmd_ready <= slow ? ~cmd_ready : 1'b1;
			rd_valid  <= 1'b0;
			// Idle data bus toggles so a stale word never passes for a return
			rd_data   <= ~rd_data;
			if (cmd_valid && cmd_ready && cmd_write)
				mem[cmd_addr[7:0]] <= cmd_wdata;
			if (cmd_valid && cmd_ready && !cmd_write) begin
				rd_valid <= 1'b1;
				rd_data  <= mem[cmd_addr[7:0]] ^ {15'h0000, flip};
			end
		end
	end
endmodule : mtp_mem_model

`default_nettype wire

// ---- dv/tb_mtp_decoder_top.sv ----
/*
 * Testbench of the pattern decoder: Wishbone register tasks, instruction runs, command monitor.
 * Assumes mtp_params.svh on the include path and the memory model beside it.
 */
`default_nettype none
`include "mtp_params.svh"

module tb_mtp_decoder_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0, flip = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0, q;
	logic [15:0] lw;
	wire  logic [31:0] wb_dat_o;
	wire  logic        ack, cmd_valid, cmd_ready, cmd_write, rd_valid;
	wire  logic [15:0] cmd_addr, cmd_wdata, rd_data;
	int n_fail = 0, total_checks = 0, nw, nr, wa, bad;
	int dpv [9] = '{4, 5, 4, 4, 5, 4, 2, 2, 5};
	int xtv [9] = '{0, 1, 2, 3, 4, 4, 5, 6, 1};
	int dlv [9] = '{0, 0, 24, 0, 0, 0, 1, 1, 9};
	logic [15:0] ewv [9] = '{16'hffff, 16'hfff7, 16'h0008, 16'hffff, 16'hfff7, 16'h0008, 16'hfff7, 16'h0010, 16'hfff7};
	int ivd [6] = '{8, 4, 7, 4, 15, 4};
	int iva [6] = '{1, 4, 1, 1, 0, 2};

	mtp_decoder_top u_mtp_decoder_top (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data));
	mtp_mem_model u_mtp_mem_model (.clk(clk), .rst_n(rst_n), .slow(slow), .flip(flip), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rd_valid(rd_valid), .rd_data(rd_data));

	initial begin
		forever #50 clk = ~clk;
	end

	// Logs accepted commands; once a write is issued, a read at an address not yet written is an ordering fault
	always @(posedge clk) begin
		if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
			if (cmd_write) begin
				nw++;
				lw = cmd_wdata;
				if (nr != 0) wa++;
			end else begin
				if (nw != 0 && cmd_addr >= nw) bad++;
				nr++;
			end
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		// Request holds until ack is seen high at a rising edge; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb

	function automatic logic [31:0] mk(input int dp, am, sub, xt, dly);
		return {14'h0000, dly[4:0], xt[2:0], sub[1:0], am[3:0], dp[3:0]};
	endfunction : mk

	task automatic run(input logic [31:0] i, input logic [15:0] c, input logic [3:0] st);
		int n;
		nw = 0;
		nr = 0;
		wa = 0;
		bad = 0;
		n = 0;
		wb(1'b1, `MTP_ADR_INSTR, i);
		wb(1'b1, `MTP_ADR_COUNT, {16'h0000, c});
		wb(1'b1, `MTP_ADR_CTRL, 32'h1);
		do begin
			wb(1'b0, `MTP_ADR_STATUS, 32'h0);
			n++;
		end while (q[2:1] === 2'b00 && n < 100);
		chk(q[3:0], st);
		chk(bad, 0);
	endtask : run

	task automatic wrap_up;
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wb(1'b0, `MTP_ADR_INSTR, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, 8'h30, 32'hffffffff);
		wb(1'b0, 8'h30, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, `MTP_ADR_TARGET, 32'h3);
		for (int k = 0; k < 9; k++) begin
			run(mk(dpv[k], 1, 1, xtv[k], dlv[k]), 16'h0005, 4'h2);
			chk(nr, 0);
			chk(lw, ewv[k]);
		end
		run(mk(4, 2, 0, 0, 0), 16'h0004, 4'h2);
		chk(nr, 4);
		chk(wa, 0);
		wb(1'b0, `MTP_ADR_ERRCNT, 32'h0);
		chk(q, 32'h0);
		slow <= 1'b1;
		flip <= 1'b1;
		run(mk(1, 2, 1, 0, 0), 16'h0008, 4'ha);
		chk(nr, 8);
		wb(1'b0, `MTP_ADR_ERRCNT, 32'h0);
		chk(q, 32'h8);
		run(mk(0, 0, 0, 0, 0), 16'h0004, 4'h2);
		chk(nw, 0);
		slow <= 1'b0;
		flip <= 1'b0;
		run(mk(7, 1, 0, 7, 0), 16'h0002, 4'h2);
		chk(lw, 16'h5555);
		wb(1'b1, `MTP_ADR_BPTR, 32'h0);
		wb(1'b1, `MTP_ADR_BDATA, 32'h1234);
		wb(1'b1, `MTP_ADR_BDATA, 32'hbeef);
		run(mk(6, 1, 0, 0, 0), 16'h0002, 4'h2);
		chk(lw, 16'hbeef);
		for (int k = 0; k < 6; k++) begin
			run(mk(ivd[k], iva[k], k == 5 ? 3 : 0, 0, k == 3 ? 25 : 0), 16'h0002, 4'h4);
			chk(nw + nr, 0);
		end
		run(mk(2, 3, 0, 0, 0), 16'h0002, 4'h1);
		chk(nw, 2);
		chk(nr > 4, 1);
		wb(1'b1, `MTP_ADR_CTRL, 32'h2);
		wb(1'b0, `MTP_ADR_STATUS, 32'h0);
		chk(q[3:0], 4'h0);
		wrap_up();
	end
endmodule : tb_mtp_decoder_top

`default_nettype wire

// ---- inc/mtp_params.svh ----
/*
 * Constants of the memory traffic pattern decoder: field codes, register map, field positions,
 * reset values and pseudo-random polynomials.
 * Assumes inclusion by bare name from the package and from the design modules.
 */
`ifndef MTP_PARAMS_SVH
`define MTP_PARAMS_SVH

// Data pattern codes
`define MTP_DP_LINEAR    4'h0
`define MTP_DP_PRBS      4'h1
`define MTP_DP_WALK1     4'h2
`define MTP_DP_WALK0     4'h3
`define MTP_DP_ONES      4'h4
`define MTP_DP_ZEROS     4'h5
`define MTP_DP_BRAM      4'h6
`define MTP_DP_CAL       4'h7

// Access modes and submodes
`define MTP_AM_READ      4'h0
`define MTP_AM_WRITE     4'h1
`define MTP_AM_WRRD      4'h2
`define MTP_AM_FOREVER   4'h3
`define MTP_SUB_SEQ      2'h0
`define MTP_SUB_INTER    2'h1

// Crosstalk modes
`define MTP_XT_NONE      3'h0
`define MTP_XT_HIGH      3'h1
`define MTP_XT_LOW       3'h2
`define MTP_XT_FOLLOW    3'h3
`define MTP_XT_INVERT    3'h4
`define MTP_XT_DAGGR     3'h5
`define MTP_XT_DVICT     3'h6
`define MTP_XT_CAL       3'h7
`define MTP_DELAY_MAX    5'h18
`define MTP_HIST_LEN     25

// Pseudo-random lengths, taps and masks
`define MTP_LFSR_W       23
`define MTP_PL_8         2'h0
`define MTP_PL_10        2'h1
`define MTP_PL_23        2'h2
`define MTP_TAPS_8       23'h0000b8
`define MTP_TAPS_10      23'h000240
`define MTP_TAPS_23      23'h420000
`define MTP_MASK_8       23'h0000ff
`define MTP_MASK_10      23'h0003ff
`define MTP_MASK_23      23'h7fffff
`define MTP_SEED         23'h000001

// Register map (byte addresses)
`define MTP_ADR_CTRL     8'h00
`define MTP_ADR_INSTR    8'h04
`define MTP_ADR_TARGET   8'h08
`define MTP_ADR_COUNT    8'h0c
`define MTP_ADR_STATUS   8'h10
`define MTP_ADR_ERRCNT   8'h14
`define MTP_ADR_BPTR     8'h18
`define MTP_ADR_BDATA    8'h1c
`define MTP_ADR_PROGRESS 8'h20

// Field positions
`define MTP_CTRL_START   0
`define MTP_CTRL_STOP    1
`define MTP_INSTR_W      20
`define MTP_F_DP         3:0
`define MTP_F_AM         7:4
`define MTP_F_SUB        9:8
`define MTP_F_XT         12:10
`define MTP_F_DLY        17:13
`define MTP_F_PL         19:18
`define MTP_ST_BUSY      0
`define MTP_ST_DONE      1
`define MTP_ST_INVALID   2
`define MTP_ST_MISMATCH  3
`define MTP_ST_W         4

// Counter width and reset values
`define MTP_CNT_W        16
`define MTP_CNT_ONE      16'h0001
`define MTP_INSTR_RST    20'h00000
`define MTP_COUNT_RST    16'h0000

`endif

// ---- inc/mtp_pkg.sv ----
/*
 * Types shared by the pattern decoder modules.
 * Assumes mtp_params.svh on the include path.
 */
`default_nettype none
`include "mtp_params.svh"

package mtp_pkg;
	typedef enum logic {MTP_IDLE, MTP_RUN} mtp_state_t;
	typedef logic [2:0] mtp_xtalk_t;
	typedef logic [4:0] mtp_delay_t;
	typedef logic [`MTP_INSTR_W-1:0] mtp_instr_t;
endpackage : mtp_pkg

`default_nettype wire

// ---- logic/mtp_decoder_top.sv ----
/*
 * Memory traffic pattern decoder: decodes instruction fields into read and write commands
 * with shaped data for a memory controller user port, and checks returned read data in write-read and read-forever accesses.
 * Assumes a classic Wishbone master on the same clock and an in-order read return.
 */
`default_nettype none
`include "mtp_params.svh"

module mtp_decoder_top #(
	parameter int IW = 4,
	parameter int AW = 16,
	parameter int BW = 4
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	output logic                     cmd_valid,
	input  wire logic                cmd_ready,
	output logic                     cmd_write,
	output logic [AW-1:0]            cmd_addr,
	output logic [(1<<IW)-1:0]       cmd_wdata,
	input  wire logic                rd_valid,
	input  wire logic [(1<<IW)-1:0]  rd_data
);
	import mtp_pkg::*;
	localparam int DW = 1 << IW;
	localparam int BRAM_DEPTH = 1 << BW;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		return (old & ~m) | (nw & m);
	endfunction : merge

	function automatic logic [`MTP_LFSR_W-1:0] lfsr_step(input logic [1:0] pl, input logic [`MTP_LFSR_W-1:0] s);
		logic [`MTP_LFSR_W-1:0] taps;
		logic [`MTP_LFSR_W-1:0] m;
		taps = `MTP_TAPS_23;
		m    = `MTP_MASK_23;
		case (pl)
			`MTP_PL_8: begin
				taps = `MTP_TAPS_8;
				m    = `MTP_MASK_8;
			end
			`MTP_PL_10: begin
				taps = `MTP_TAPS_10;
				m    = `MTP_MASK_10;
			end
			default: begin
				taps = `MTP_TAPS_23;
				m    = `MTP_MASK_23;
			end
		endcase
		return {s[`MTP_LFSR_W-2:0], ^(s & taps)} & m;
	endfunction : lfsr_step

	// Base data word of the idx-th access, before crosstalk shaping
	function automatic logic [DW-1:0] pattern(input logic [3:0] dp, input logic [`MTP_CNT_W-1:0] idx,
		input logic [`MTP_LFSR_W-1:0] prbs, input logic [DW-1:0] ram);
		logic [DW-1:0] p;
		p = '0;
		for (int b = 0; b < DW; b++) begin
			case (dp)
				`MTP_DP_LINEAR: p[b] = idx[b % `MTP_CNT_W];
				`MTP_DP_PRBS:   p[b] = prbs[b % `MTP_LFSR_W];
				`MTP_DP_WALK1:  p[b] = (idx[IW-1:0] == IW'(b));
				`MTP_DP_WALK0:  p[b] = (idx[IW-1:0] != IW'(b));
				`MTP_DP_ONES:   p[b] = 1'b1;
				`MTP_DP_ZEROS:  p[b] = 1'b0;
				`MTP_DP_BRAM:   p[b] = ram[b];
				`MTP_DP_CAL:    p[b] = idx[0] ^ idx[2] ^ b[0];
				default:        p[b] = 1'b0;
			endcase
		end
		return p;
	endfunction : pattern

	logic                   wb_ack_q;
	logic [31:0]            wb_dat_q;
	mtp_instr_t             instr_q;
	mtp_instr_t             run_instr_q;
	logic [IW-1:0]          target_q;
	logic [IW-1:0]          run_target_q;
	logic [`MTP_CNT_W-1:0]  count_q;
	logic [`MTP_CNT_W-1:0]  run_count_q;
	logic [BW-1:0]          bptr_q;
	logic [DW-1:0]          bram_q [BRAM_DEPTH];
	mtp_state_t             state_q;
	logic [`MTP_CNT_W-1:0]  wr_cnt_q;
	logic [`MTP_CNT_W-1:0]  rd_cnt_q;
	logic [`MTP_CNT_W-1:0]  chk_cnt_q;
	logic [`MTP_CNT_W-1:0]  errcnt_q;
	logic [`MTP_LFSR_W-1:0] lfsr_w_q;
	logic [`MTP_LFSR_W-1:0] lfsr_r_q;
	logic [`MTP_LFSR_W-1:0] mix_q;
	logic                   done_q;
	logic                   invalid_q;
	logic                   err_q;
	logic                   cmd_valid_q;
	logic                   cmd_write_q;
	logic [AW-1:0]          cmd_addr_q;
	logic [DW-1:0]          cmd_wdata_q;
	logic [DW-1:0]          shaped_w;
	logic [DW-1:0]          shaped_r;

	// Register bus decode
	wire        wb_req   = wb_cyc_i & wb_stb_i;
	wire        wb_wr    = wb_req & wb_we_i & wb_ack_q;
	wire [31:0] wb_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] ctrl_new = merge(32'h0, wb_dat_i, wb_mask);
	wire [31:0] instr_nw = merge({{(32-`MTP_INSTR_W){1'b0}}, instr_q}, wb_dat_i, wb_mask);
	wire [31:0] tgt_nw   = merge({{(32-IW){1'b0}}, target_q}, wb_dat_i, wb_mask);
	wire [31:0] cnt_nw   = merge({{(32-`MTP_CNT_W){1'b0}}, count_q}, wb_dat_i, wb_mask);
	wire [31:0] bptr_nw  = merge({{(32-BW){1'b0}}, bptr_q}, wb_dat_i, wb_mask);
	wire        wr_ctrl  = wb_wr & (wb_adr_i == `MTP_ADR_CTRL);
	wire        wr_instr = wb_wr & (wb_adr_i == `MTP_ADR_INSTR);
	wire        wr_tgt   = wb_wr & (wb_adr_i == `MTP_ADR_TARGET);
	wire        wr_cnt   = wb_wr & (wb_adr_i == `MTP_ADR_COUNT);
	wire        wr_bptr  = wb_wr & (wb_adr_i == `MTP_ADR_BPTR);
	wire        wr_bdata = wb_wr & (wb_adr_i == `MTP_ADR_BDATA);
	wire        running  = (state_q == MTP_RUN);
	wire        start_p  = wr_ctrl & ctrl_new[`MTP_CTRL_START] & ~running;
	wire        stop_p   = wr_ctrl & ctrl_new[`MTP_CTRL_STOP] & running;

	// Instruction check at start
	wire [3:0] dp_n  = instr_q[`MTP_F_DP];
	wire [3:0] am_n  = instr_q[`MTP_F_AM];
	wire       ok_n  = (dp_n <= `MTP_DP_CAL) & (am_n <= `MTP_AM_FOREVER)
		& ((am_n != `MTP_AM_WRRD) | (instr_q[`MTP_F_SUB] <= `MTP_SUB_INTER))
		& (instr_q[`MTP_F_DLY] <= `MTP_DELAY_MAX)
		& (instr_q[`MTP_F_PL] <= `MTP_PL_23)
		& ((dp_n == `MTP_DP_CAL) == (instr_q[`MTP_F_XT] == `MTP_XT_CAL))
		& (count_q != '0);

	// Fields of the running instruction
	wire [3:0]       dp_r  = run_instr_q[`MTP_F_DP];
	wire [3:0]       am_r  = run_instr_q[`MTP_F_AM];
	wire [1:0]       sub_r = run_instr_q[`MTP_F_SUB];
	wire mtp_xtalk_t xt_r  = run_instr_q[`MTP_F_XT];
	wire mtp_delay_t dly_r = run_instr_q[`MTP_F_DLY];
	wire [1:0]       pl_r  = run_instr_q[`MTP_F_PL];

	// Command selection
	wire issue_slot = running & (~cmd_valid_q | cmd_ready);
	wire wr_left    = wr_cnt_q < run_count_q;
	wire rd_left    = rd_cnt_q < run_count_q;
	wire rd_behind  = rd_cnt_q < wr_cnt_q;
	wire wrrd       = (am_r == `MTP_AM_WRRD);
	wire seq_sub    = wrrd & (sub_r == `MTP_SUB_SEQ);
	wire int_sub    = wrrd & (sub_r == `MTP_SUB_INTER);
	wire want_wr    = wr_left & ((am_r == `MTP_AM_WRITE) | seq_sub | (am_r == `MTP_AM_FOREVER)
		| (int_sub & (~rd_behind | mix_q[0])));
	wire want_rd    = ~want_wr & (((am_r == `MTP_AM_READ) & rd_left) | (seq_sub & rd_left)
		| (int_sub & rd_behind) | (am_r == `MTP_AM_FOREVER));
	wire issue_wr   = issue_slot & want_wr;
	wire issue_rd   = issue_slot & want_rd;
	wire rd_wrap    = (am_r == `MTP_AM_FOREVER) & (rd_cnt_q == run_count_q - `MTP_CNT_ONE);

	// Read return check
	wire check_en   = wrrd | (am_r == `MTP_AM_FOREVER);
	wire chk_go     = running & rd_valid & check_en;
	wire chk_wrap   = chk_go & (am_r == `MTP_AM_FOREVER) & (chk_cnt_q == run_count_q - `MTP_CNT_ONE);
	wire mismatch   = chk_go & (rd_data != shaped_r);
	wire all_done   = running & ~want_wr & ~want_rd & ~cmd_valid_q & (~check_en | (chk_cnt_q == run_count_q));

	wire [DW-1:0] base_w = pattern(dp_r, wr_cnt_q, lfsr_w_q, bram_q[wr_cnt_q[BW-1:0]]);
	wire [DW-1:0] base_r = pattern(dp_r, chk_cnt_q, lfsr_r_q, bram_q[chk_cnt_q[BW-1:0]]);

	mtp_xtalk_shaper #(.IW(IW)) u_shape_wr (
		.clk    (clk),
		.rst_n  (rst_n),
		.clr    (start_p),
		.adv    (issue_wr),
		.mode   (xt_r),
		.delay  (dly_r),
		.target (run_target_q),
		.base   (base_w),
		.shaped (shaped_w)
	);

	mtp_xtalk_shaper #(.IW(IW)) u_shape_rd (
		.clk    (clk),
		.rst_n  (rst_n),
		.clr    (start_p | chk_wrap),
		.adv    (chk_go),
		.mode   (xt_r),
		.delay  (dly_r),
		.target (run_target_q),
		.base   (base_r),
		.shaped (shaped_r)
	);

	// Read mux
	wire [`MTP_ST_W-1:0] status = {err_q, invalid_q, done_q, running};
	wire [31:0] rd_mux =
		(wb_adr_i == `MTP_ADR_INSTR)    ? {{(32-`MTP_INSTR_W){1'b0}}, instr_q} :
		(wb_adr_i == `MTP_ADR_TARGET)   ? {{(32-IW){1'b0}}, target_q} :
		(wb_adr_i == `MTP_ADR_COUNT)    ? {{(32-`MTP_CNT_W){1'b0}}, count_q} :
		(wb_adr_i == `MTP_ADR_STATUS)   ? {{(32-`MTP_ST_W){1'b0}}, status} :
		(wb_adr_i == `MTP_ADR_ERRCNT)   ? {{(32-`MTP_CNT_W){1'b0}}, errcnt_q} :
		(wb_adr_i == `MTP_ADR_BPTR)     ? {{(32-BW){1'b0}}, bptr_q} :
		(wb_adr_i == `MTP_ADR_PROGRESS) ? {{(32-`MTP_CNT_W){1'b0}}, chk_cnt_q} : 32'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_q <= 1'b0;
			wb_dat_q <= 32'h0;
		end else begin
			wb_ack_q <= wb_req & ~wb_ack_q;
			wb_dat_q <= (wb_req & ~wb_ack_q) ? rd_mux : wb_dat_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_q  <= `MTP_INSTR_RST;
			target_q <= '0;
			count_q  <= `MTP_COUNT_RST;
			bptr_q   <= '0;
		end else begin
			instr_q  <= wr_instr ? instr_nw[`MTP_INSTR_W-1:0] : instr_q;
			target_q <= wr_tgt ? tgt_nw[IW-1:0] : target_q;
			count_q  <= wr_cnt ? cnt_nw[`MTP_CNT_W-1:0] : count_q;
			bptr_q   <= wr_bptr ? bptr_nw[BW-1:0] : (wr_bdata ? bptr_q + BW'(1) : bptr_q);
		end
	end

	// Pattern table has no reset; software loads it before use
	always_ff @(posedge clk) begin
		if (wr_bdata) begin
			bram_q[bptr_q] <= wb_dat_i[DW-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q      <= MTP_IDLE;
			run_instr_q  <= `MTP_INSTR_RST;
			run_target_q <= '0;
			run_count_q  <= `MTP_COUNT_RST;
			invalid_q    <= 1'b0;
			done_q       <= 1'b0;
		end else begin
			case (state_q)
				MTP_IDLE: state_q <= (start_p & ok_n) ? MTP_RUN : MTP_IDLE;
				MTP_RUN:  state_q <= (stop_p | all_done) ? MTP_IDLE : MTP_RUN;
				default:  state_q <= MTP_IDLE;
			endcase
			run_instr_q  <= start_p ? instr_q : run_instr_q;
			run_target_q <= start_p ? target_q : run_target_q;
			run_count_q  <= start_p ? count_q : run_count_q;
			invalid_q    <= start_p ? ~ok_n : invalid_q;
			done_q       <= all_done | (done_q & ~start_p);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_cnt_q  <= '0;
			rd_cnt_q  <= '0;
			lfsr_w_q  <= `MTP_SEED;
			mix_q     <= `MTP_SEED;
		end else begin
			wr_cnt_q  <= start_p ? '0 : (issue_wr ? wr_cnt_q + `MTP_CNT_ONE : wr_cnt_q);
			rd_cnt_q  <= (start_p | (issue_rd & rd_wrap)) ? '0 : (issue_rd ? rd_cnt_q + `MTP_CNT_ONE : rd_cnt_q);
			lfsr_w_q  <= start_p ? `MTP_SEED : (issue_wr ? lfsr_step(pl_r, lfsr_w_q) : lfsr_w_q);
			mix_q     <= start_p ? `MTP_SEED : (issue_slot ? lfsr_step(`MTP_PL_8, mix_q) : mix_q);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chk_cnt_q <= '0;
			lfsr_r_q  <= `MTP_SEED;
			errcnt_q  <= '0;
			err_q     <= 1'b0;
		end else begin
			chk_cnt_q <= (start_p | chk_wrap) ? '0 : (chk_go ? chk_cnt_q + `MTP_CNT_ONE : chk_cnt_q);
			lfsr_r_q  <= (start_p | chk_wrap) ? `MTP_SEED : (chk_go ? lfsr_step(pl_r, lfsr_r_q) : lfsr_r_q);
			errcnt_q  <= start_p ? '0 : (mismatch ? errcnt_q + `MTP_CNT_ONE : errcnt_q);
			err_q     <= mismatch | (err_q & ~start_p);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid_q <= 1'b0;
			cmd_write_q <= 1'b0;
			cmd_addr_q  <= '0;
			cmd_wdata_q <= '0;
		end else if (~running | stop_p) begin
			cmd_valid_q <= 1'b0;
		end else if (issue_slot) begin
			cmd_valid_q <= issue_wr | issue_rd;
			cmd_write_q <= issue_wr;
			cmd_addr_q  <= issue_wr ? AW'(wr_cnt_q) : AW'(rd_cnt_q);
			cmd_wdata_q <= issue_wr ? shaped_w : '0;
		end
	end

	assign wb_ack_o  = wb_ack_q;
	assign wb_dat_o  = wb_dat_q;
	assign cmd_valid = cmd_valid_q;
	assign cmd_write = cmd_write_q;
	assign cmd_addr  = cmd_addr_q;
	assign cmd_wdata = cmd_wdata_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_ones_write;
		cmd_valid_q && cmd_write_q && dp_r == `MTP_DP_ONES && xt_r == `MTP_XT_NONE;
	endsequence
	sequence s_bad_read;
		running && rd_valid && check_en && rd_data != shaped_r;
	endsequence

	a_hammer_ones: assert property (s_ones_write |-> &cmd_wdata_q)
		else $error("all-ones pattern not all ones");
	a_read_only: assert property ((cmd_valid_q && am_r == `MTP_AM_READ) |-> !cmd_write_q)
		else $error("write issued in read-only access");
	a_read_nocheck: assert property ((running && am_r == `MTP_AM_READ) |=> !$rose(err_q))
		else $error("read-only access flagged a mismatch");
	a_write_only: assert property ((cmd_valid_q && am_r == `MTP_AM_WRITE) |-> cmd_write_q)
		else $error("read issued in write-only access");
	a_mismatch_flag: assert property (s_bad_read |=> err_q && errcnt_q == $past(errcnt_q) + `MTP_CNT_ONE)
		else $error("mismatch not recorded");
	a_forever_run: assert property ((running && am_r == `MTP_AM_FOREVER && !stop_p) |=> running)
		else $error("read-forever access ended by itself");
	a_seq_order: assert property ((cmd_valid_q && !cmd_write_q && seq_sub) |-> wr_cnt_q == run_count_q)
		else $error("read before all writes in sequential submode");
	a_write_first: assert property ((cmd_valid_q && !cmd_write_q && wrrd) |-> cmd_addr_q < AW'(wr_cnt_q))
		else $error("read of an unwritten location");
	a_delay_limit: assert property (running |-> dly_r <= `MTP_DELAY_MAX)
		else $error("run with delay above limit");
	a_invalid_block: assert property ((start_p && !ok_n) |=> (!running && invalid_q) [*2])
		else $error("invalid instruction started traffic");
endmodule : mtp_decoder_top

`default_nettype wire

// ---- logic/mtp_xtalk_shaper.sv ----
/*
 * Crosstalk shaper: forces the neighbours of one target bit, or the target bit itself,
 * from a base data word, with an optional delay history counted in generated words.
 * Assumes the delay has been checked against its limit before a run starts.
 */
`default_nettype none
`include "mtp_params.svh"

module mtp_xtalk_shaper #(
	parameter int IW = 4
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               clr,
	input  wire logic               adv,
	input  wire mtp_pkg::mtp_xtalk_t mode,
	input  wire mtp_pkg::mtp_delay_t delay,
	input  wire logic [IW-1:0]      target,
	input  wire logic [(1<<IW)-1:0] base,
	output logic [(1<<IW)-1:0]      shaped
);
	import mtp_pkg::*;
	localparam int DW = 1 << IW;

	logic [`MTP_HIST_LEN-1:0] hist_v_q;
	logic [`MTP_HIST_LEN-1:0] hist_a_q;
	logic [IW-1:0]            nb;
	logic                     victim;
	logic                     aggr;
	logic                     dly_v;
	logic                     dly_a;

	// Nearest neighbour stands for the aggressor group when the target lags it
	assign nb     = target + IW'(1);
	assign victim = base[target];
	assign aggr   = base[nb];
	assign dly_v  = (delay == '0) ? victim : hist_v_q[delay - 5'h1];
	assign dly_a  = (delay == '0) ? aggr : hist_a_q[delay - 5'h1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hist_v_q <= '0;
			hist_a_q <= '0;
		end else if (clr) begin
			hist_v_q <= '0;
			hist_a_q <= '0;
		end else if (adv) begin
			hist_v_q <= {hist_v_q[`MTP_HIST_LEN-2:0], victim};
			hist_a_q <= {hist_a_q[`MTP_HIST_LEN-2:0], aggr};
		end
	end

	genvar b;
	generate
		for (b = 0; b < DW; b++) begin : g_bit
			// Every bit except the target is an aggressor
			assign shaped[b] = (target == IW'(b)) ? ((mode == `MTP_XT_DVICT) ? dly_a : base[b]) :
				(mode == `MTP_XT_HIGH)   ? 1'b1 :
				(mode == `MTP_XT_LOW)    ? 1'b0 :
				(mode == `MTP_XT_FOLLOW) ? victim :
				(mode == `MTP_XT_INVERT) ? ~victim :
				(mode == `MTP_XT_DAGGR)  ? dly_v : base[b];
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_held_high: assert property ((mode == `MTP_XT_HIGH) |-> &(shaped | (DW'(1) << target)))
		else $error("aggressors not held high");
	a_neighbour_inv: assert property ((mode == `MTP_XT_INVERT) |-> shaped[nb] == ~base[target])
		else $error("aggressor not inverse of target");
	a_delay_aggr: assert property ((mode == `MTP_XT_DAGGR && delay == 5'h1 && $past(adv) && !$past(clr))
		|-> shaped[nb] == $past(base[target]))
		else $error("aggressor not delayed target copy");
	a_delay_victim: assert property ((mode == `MTP_XT_DVICT && delay == 5'h1 && $past(adv) && !$past(clr))
		|-> shaped[target] == $past(base[nb]))
		else $error("target not delayed aggressor copy");
	a_delay_unused: assert property ((mode == `MTP_XT_FOLLOW) |-> shaped[nb] == base[target])
		else $error("delay leaked into follow mode");
endmodule : mtp_xtalk_shaper

`default_nettype wire
